// File: include/smss_consts.svh
// register offsets, field positions, reset values and timing counts of the supply monitor
// Summary of operation
// R1: analog regulator overvoltage sets sticky rail flag
// R2: analog undervoltage resets digital, flags cause afterward
// R3: analog regulator oscillation sets system flag b
// R4: transceiver regulator overvoltage sets rail flag
// R5: digital regulator overvoltage sets rail flag
// R6: digital regulator low holds logic in reset
// R7: digital ground open sets system flag b
// R8: bias reference enabled only by control bit
// R9: host waits bias settle before input measurements
// R10: bias reference over/undervoltage set rail flags
// R11: bias reference oscillation sets system flag b
// R12: always-on overvoltage flags; undervoltage forces power-on reset
// R13: transceiver supply undervoltage sets rail flag
// R14: transceiver ground open sets system flag b
// R15: io supply undervoltage sets system flag c
// R16: host never toggles io supply in shutdown
// R17: host first broadcasts zero to error test register
// R18: host enables address writes, then assigns addresses
// R19: host sets base, stack and top bits
// R20: host dummy reads, then clears chain faults
// R21: host waits wake settle before power commands
// R22: fault flags stay set until host clears; code also clears the analog undervoltage cause during power-on reset
`ifndef SMSS_CONSTS_SVH
`define SMSS_CONSTS_SVH
`define SMSS_OFS_RAIL_FAULT   12'h000
`define SMSS_OFS_SYS_FAULT_A  12'h004
`define SMSS_OFS_SYS_FAULT_B  12'h008
`define SMSS_OFS_SYS_FAULT_C  12'h00C
`define SMSS_OFS_CONTROL_A    12'h010
`define SMSS_OFS_CONTROL_B    12'h014
`define SMSS_OFS_DEV_ADDR     12'h018
`define SMSS_OFS_STACK_CFG    12'h01C
`define SMSS_OFS_ERR_TEST     12'h020
`define SMSS_OFS_STATUS       12'h024
// rail fault bits
`define SMSS_RF_ANA_OV        0
`define SMSS_RF_ANA_UV_RST    1
`define SMSS_RF_XCV_REG_OV    2
`define SMSS_RF_DIG_OV        3
`define SMSS_RF_BIAS_OV       4
`define SMSS_RF_BIAS_UV       5
`define SMSS_RF_XCV_SUP_UV    6
// system fault bits
`define SMSS_SFA_AON_OV       0
`define SMSS_SFB_ANA_OSC      0
`define SMSS_SFB_BIAS_OSC     1
`define SMSS_SFB_DIG_GND_OPEN 2
`define SMSS_SFB_XCV_GND_OPEN 3
`define SMSS_SFC_IO_UV        0
// control bits
`define SMSS_CA_ADDR_WR_EN    0
`define SMSS_CB_BIAS_EN       0
`define SMSS_SC_STACK_MEMBER  0
`define SMSS_SC_TOP_STACK     1
`define SMSS_RST_VALUE        32'h0000_0000
`define SMSS_ADDR_W           6
// oscillation detection blanking after bias start
`define SMSS_BLANK_MS         10
`define SMSS_CLK_HZ           50000000
`define SMSS_BLANK_CYC        ((`SMSS_BLANK_MS * `SMSS_CLK_HZ) / 1000)
`endif

// File: include/smss_pkg.sv
// types shared by the supply monitor files
package smss_pkg;
  typedef struct packed {
    logic ana_ov;
    logic ana_uv;
    logic ana_osc;
    logic xcv_reg_ov;
    logic dig_ov;
    logic dig_low;
    logic dig_gnd_open;
    logic bias_ov;
    logic bias_uv;
    logic bias_osc;
    logic aon_ov;
    logic aon_uv;
    logic xcv_sup_uv;
    logic xcv_gnd_open;
    logic io_uv;
  } smss_cmp_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } smss_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } smss_apb_rsp_t;

  typedef enum logic [2:0] {
    SMSS_RUN   = 3'b001,
    SMSS_DRST  = 3'b010,
    SMSS_POR   = 3'b100
  } smss_state_t;
endpackage

// File: hw/smss_sticky_flag.sv
// one sticky fault flag: set wins over clear
`timescale 1ns/10ps
`default_nettype none
module smss_sticky_flag (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // event and clear
  input  wire logic i_set,
  input  wire logic i_clr,
  // flag
  output logic      o_flag
);
  logic flag_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (i_set) begin
      flag_q <= 1'b1; // R22
    end else if (i_clr) begin
      flag_q <= 1'b0;
    end
  end
  assign o_flag = flag_q;
endmodule
`default_nettype wire

// File: hw/smss_blank_timer.sv
// counts out the blanking window after a start event
`timescale 1ns/10ps
`default_nettype none
module smss_blank_timer #(
  parameter int unsigned CYCLES = 1
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // control
  input  wire logic i_run,
  // window over
  output logic      o_done
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_run) begin
      cnt_q <= '0;
    end else if (cnt_q != W'(CYCLES)) begin
      cnt_q <= cnt_q + W'(1);
    end
  end
  assign o_done = i_run && (cnt_q == W'(CYCLES));
endmodule
`default_nettype wire

// File: hw/smss_top.sv
// supply-rail supervision, reset generation and start-up registers
`include "smss_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module smss_top #(
  parameter int unsigned BLANK_CYC = `SMSS_BLANK_CYC
) (
  // clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  // comparator levels
  input  wire smss_pkg::smss_cmp_t   i_cmp,
  // apb slave
  input  wire smss_pkg::smss_apb_req_t i_apb,
  output smss_pkg::smss_apb_rsp_t    o_apb,
  // reset and enable outputs
  output logic                       o_digital_reset,
  output logic                       o_power_on_reset,
  output logic                       o_bias_reference_enable
);
  import smss_pkg::*;

  typedef struct packed {
    smss_state_t        st;
    logic               uv_cause;
    logic               addr_wr_en;
    logic               bias_en;
    logic [`SMSS_ADDR_W-1:0] dev_addr;
    logic               stack_member;
    logic               top_stack;
    logic [7:0]         err_test;
    smss_apb_rsp_t      rsp;
    logic               drst;
    logic               por;
    logic               bias_out;
  } smss_top_t;

  smss_top_t s_q;
  smss_top_t s_d;

  localparam int NF = 12;
  logic [NF-1:0] f_set;
  logic [NF-1:0] f_clr;
  logic [NF-1:0] f_val;
  logic          osc_ok;
  logic          in_reset;
  logic          wr_acc;
  logic          rd_acc;
  logic [31:0]   rdat;
  logic [31:0]   rail_word;

  // flags run while digital logic is up; reset-kind flags are latched separately
  assign in_reset = (s_q.st != SMSS_RUN);
  assign wr_acc = i_apb.psel && i_apb.penable && i_apb.pwrite && !s_q.rsp.pready && !in_reset;
  assign rd_acc = i_apb.psel && i_apb.penable && !i_apb.pwrite && !s_q.rsp.pready && !in_reset;

  // bias oscillation and bias undervoltage detectors ignore the bias start transient
  smss_blank_timer #(
    .CYCLES (BLANK_CYC)
  ) u_blank (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (s_q.bias_out),
    .o_done    (osc_ok)
  );

  always_comb begin
    f_set = '0;
    f_set[0]  = i_cmp.ana_ov;                 // R1
    f_set[1]  = i_cmp.xcv_reg_ov;             // R4
    f_set[2]  = i_cmp.dig_ov;                 // R5
    f_set[3]  = i_cmp.bias_ov && s_q.bias_out; // R10
    f_set[4]  = i_cmp.bias_uv && osc_ok;      // R10
    f_set[5]  = i_cmp.xcv_sup_uv;             // R13
    f_set[6]  = i_cmp.aon_ov;                 // R12
    f_set[7]  = i_cmp.ana_osc;                // R3
    f_set[8]  = i_cmp.bias_osc && osc_ok;     // R11
    f_set[9]  = i_cmp.dig_gnd_open;           // R7
    f_set[10] = i_cmp.xcv_gnd_open;           // R14
    f_set[11] = i_cmp.io_uv;                  // R15
    if (in_reset) begin
      f_set = '0;
    end
  end

  // write-one-to-clear on the fault words
  always_comb begin
    f_clr = '0;
    if (wr_acc) begin
      case (i_apb.paddr)
        `SMSS_OFS_RAIL_FAULT: begin
          f_clr[0] = i_apb.pwdata[`SMSS_RF_ANA_OV];
          f_clr[1] = i_apb.pwdata[`SMSS_RF_XCV_REG_OV];
          f_clr[2] = i_apb.pwdata[`SMSS_RF_DIG_OV];
          f_clr[3] = i_apb.pwdata[`SMSS_RF_BIAS_OV];
          f_clr[4] = i_apb.pwdata[`SMSS_RF_BIAS_UV];
          f_clr[5] = i_apb.pwdata[`SMSS_RF_XCV_SUP_UV];
        end
        `SMSS_OFS_SYS_FAULT_A: begin
          f_clr[6] = i_apb.pwdata[`SMSS_SFA_AON_OV];
        end
        `SMSS_OFS_SYS_FAULT_B: begin
          f_clr[7]  = i_apb.pwdata[`SMSS_SFB_ANA_OSC];
          f_clr[8]  = i_apb.pwdata[`SMSS_SFB_BIAS_OSC];
          f_clr[9]  = i_apb.pwdata[`SMSS_SFB_DIG_GND_OPEN];
          f_clr[10] = i_apb.pwdata[`SMSS_SFB_XCV_GND_OPEN];
        end
        `SMSS_OFS_SYS_FAULT_C: begin
          f_clr[11] = i_apb.pwdata[`SMSS_SFC_IO_UV];
        end
        default: begin
          f_clr = '0;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_flag
      smss_sticky_flag u_flag (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_set     (f_set[g]),
        .i_clr     (f_clr[g]),
        .o_flag    (f_val[g])
      );
    end
  endgenerate

  always_comb begin
    rail_word = 32'h0000_0000;
    rail_word[`SMSS_RF_ANA_OV]     = f_val[0];
    rail_word[`SMSS_RF_ANA_UV_RST] = s_q.uv_cause;
    rail_word[`SMSS_RF_XCV_REG_OV] = f_val[1];
    rail_word[`SMSS_RF_DIG_OV]     = f_val[2];
    rail_word[`SMSS_RF_BIAS_OV]    = f_val[3];
    rail_word[`SMSS_RF_BIAS_UV]    = f_val[4];
    rail_word[`SMSS_RF_XCV_SUP_UV] = f_val[5];
  end

  always_comb begin
    rdat = 32'h0000_0000;
    case (i_apb.paddr)
      `SMSS_OFS_RAIL_FAULT:  rdat = rail_word;
      `SMSS_OFS_SYS_FAULT_A: rdat[`SMSS_SFA_AON_OV] = f_val[6];
      `SMSS_OFS_SYS_FAULT_B: begin
        rdat[`SMSS_SFB_ANA_OSC]      = f_val[7];
        rdat[`SMSS_SFB_BIAS_OSC]     = f_val[8];
        rdat[`SMSS_SFB_DIG_GND_OPEN] = f_val[9];
        rdat[`SMSS_SFB_XCV_GND_OPEN] = f_val[10];
      end
      `SMSS_OFS_SYS_FAULT_C: rdat[`SMSS_SFC_IO_UV] = f_val[11];
      `SMSS_OFS_CONTROL_A:   rdat[`SMSS_CA_ADDR_WR_EN] = s_q.addr_wr_en;
      `SMSS_OFS_CONTROL_B:   rdat[`SMSS_CB_BIAS_EN] = s_q.bias_en;
      `SMSS_OFS_DEV_ADDR:    rdat[`SMSS_ADDR_W-1:0] = s_q.dev_addr;
      `SMSS_OFS_STACK_CFG: begin
        rdat[`SMSS_SC_STACK_MEMBER] = s_q.stack_member;
        rdat[`SMSS_SC_TOP_STACK]    = s_q.top_stack;
      end
      `SMSS_OFS_ERR_TEST:    rdat[7:0] = s_q.err_test;
      `SMSS_OFS_STATUS:      rdat[0] = osc_ok;
      default:               rdat = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.rsp.pready  = 1'b0;
    s_d.rsp.pslverr = 1'b0;
    // reset kinds: power-on outranks digital reset
    case (s_q.st)
      SMSS_RUN: begin
        if (i_cmp.aon_uv) begin
          s_d.st = SMSS_POR; // R12
        end else if (i_cmp.ana_uv || i_cmp.dig_low) begin
          s_d.st = SMSS_DRST; // R2 R6
        end
      end
      SMSS_DRST: begin
        if (i_cmp.aon_uv) begin
          s_d.st = SMSS_POR;
        end else if (!i_cmp.ana_uv && !i_cmp.dig_low) begin
          s_d.st = SMSS_RUN;
        end
        if (i_cmp.ana_uv) begin
          s_d.uv_cause = 1'b1; // R2
        end
      end
      SMSS_POR: begin
        if (!i_cmp.aon_uv) begin
          s_d.st = SMSS_RUN;
        end
      end
      default: s_d.st = SMSS_POR;
    endcase
    if (in_reset) begin
      // digital logic held: control state returns to defaults
      s_d.addr_wr_en   = 1'b0;
      s_d.bias_en      = 1'b0;
      s_d.dev_addr     = '0;
      s_d.stack_member = 1'b0;
      s_d.top_stack    = 1'b0;
      s_d.err_test     = 8'h00;
      s_d.rsp.prdata   = 32'h0000_0000;
      if (s_q.st == SMSS_POR) begin
        s_d.uv_cause = 1'b0;
      end
    end else if (i_apb.psel && i_apb.penable && !s_q.rsp.pready) begin
      s_d.rsp.pready = 1'b1;
      s_d.rsp.prdata = rd_acc ? rdat : 32'h0000_0000;
      if (wr_acc) begin
        case (i_apb.paddr)
          `SMSS_OFS_RAIL_FAULT: begin
            if (i_apb.pwdata[`SMSS_RF_ANA_UV_RST]) begin
              s_d.uv_cause = 1'b0; // R22
            end
          end
          `SMSS_OFS_CONTROL_A:  s_d.addr_wr_en = i_apb.pwdata[`SMSS_CA_ADDR_WR_EN];
          `SMSS_OFS_CONTROL_B:  s_d.bias_en = i_apb.pwdata[`SMSS_CB_BIAS_EN];
          `SMSS_OFS_DEV_ADDR: begin
            // address only lands while address writes are enabled
            if (s_q.addr_wr_en) begin
              s_d.dev_addr = i_apb.pwdata[`SMSS_ADDR_W-1:0];
            end
          end
          `SMSS_OFS_STACK_CFG: begin
            s_d.stack_member = i_apb.pwdata[`SMSS_SC_STACK_MEMBER];
            s_d.top_stack    = i_apb.pwdata[`SMSS_SC_TOP_STACK];
          end
          `SMSS_OFS_ERR_TEST:   s_d.err_test = i_apb.pwdata[7:0];
          `SMSS_OFS_SYS_FAULT_A, `SMSS_OFS_SYS_FAULT_B,
          `SMSS_OFS_SYS_FAULT_C, `SMSS_OFS_STATUS: begin
            s_d.rsp.pslverr = 1'b0;
          end
          default: s_d.rsp.pslverr = 1'b1;
        endcase
      end else if (rdat == 32'h0000_0000 && i_apb.paddr > `SMSS_OFS_STATUS) begin
        s_d.rsp.pslverr = 1'b1;
      end
    end
    s_d.drst     = (s_d.st == SMSS_DRST);
    s_d.por      = (s_d.st == SMSS_POR);
    s_d.bias_out = s_d.bias_en && (s_d.st == SMSS_RUN); // R8
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q <= '{st: SMSS_RUN, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_apb                   = s_q.rsp;
  assign o_digital_reset         = s_q.drst;
  assign o_power_on_reset        = s_q.por;
  assign o_bias_reference_enable = s_q.bias_out;
endmodule
`default_nettype wire

// File: testbench/smss_monitor.sv
// port checker of the supply monitor
`timescale 1ns/10ps
`default_nettype none
module smss_monitor #(
  parameter int unsigned BLANK_CYC = 8
) (
  // clock and reset
  input wire logic                    i_clk_sys,
  input wire logic                    i_rst,
  // watched ports
  input wire smss_pkg::smss_cmp_t     i_cmp,
  input wire smss_pkg::smss_apb_req_t i_apb,
  input wire smss_pkg::smss_apb_rsp_t o_apb,
  input wire logic                    o_digital_reset,
  input wire logic                    o_power_on_reset,
  input wire logic                    o_bias_reference_enable
);
  import smss_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic in_rst;
  logic wr_bias;
  assign in_rst = o_digital_reset | o_power_on_reset;
  assign wr_bias = i_apb.psel & i_apb.penable & i_apb.pwrite & o_apb.pready
                   & (i_apb.paddr == 12'h014);
  sequence acc_first;
    $rose(i_apb.penable) && i_apb.psel && !in_rst;
  endsequence
  sequence one_wait;
    !o_apb.pready ##1 o_apb.pready;
  endsequence
  por_entry_a: assert property (i_cmp.aon_uv |=> o_power_on_reset)
    else $error("power-on reset not entered");
  por_prio_a: assert property (i_cmp.aon_uv [*2] |-> o_power_on_reset && !o_digital_reset)
    else $error("power-on reset lost priority");
  drst_ana_a: assert property (i_cmp.ana_uv && !i_cmp.aon_uv |=> o_digital_reset)
    else $error("analog undervoltage gave no digital reset");
  drst_dig_a: assert property (i_cmp.dig_low && !i_cmp.aon_uv |=> o_digital_reset)
    else $error("digital low gave no digital reset");
  drst_exit_a: assert property (o_digital_reset && !i_cmp.ana_uv && !i_cmp.dig_low
    && !i_cmp.aon_uv |=> !o_digital_reset)
    else $error("digital reset held too long");
  // the enable is registered with the write, so it rises at the answering edge
  bias_cause_a: assert property ($rose(o_bias_reference_enable) |-> wr_bias)
    else $error("bias enabled without control write");
  bias_off_a: assert property (in_rst [*2] |-> !o_bias_reference_enable)
    else $error("bias on during internal reset");
  ack_rst_a: assert property (in_rst [*2] |-> !o_apb.pready)
    else $error("bus answered during internal reset");
  wait_state_a: assert property (acc_first |-> one_wait)
    else $error("bus answer not after one wait state");
  bad_addr_a: assert property (o_apb.pready && i_apb.psel && i_apb.paddr > 12'h024
    |-> o_apb.pslverr)
    else $error("unmapped access not refused");
endmodule
bind smss_top smss_monitor #(.BLANK_CYC(BLANK_CYC)) smss_monitor_i (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmp(i_cmp), .i_apb(i_apb), .o_apb(o_apb),
  .o_digital_reset(o_digital_reset), .o_power_on_reset(o_power_on_reset),
  .o_bias_reference_enable(o_bias_reference_enable));
`default_nettype wire

// File: testbench/smss_host_model.sv
// apb host that runs the start-up sequence
`timescale 1ns/10ps
`default_nettype none
module smss_host_model (
  // clock
  input wire logic                    i_clk_sys,
  // apb
  input wire smss_pkg::smss_apb_rsp_t i_rsp,
  output var smss_pkg::smss_apb_req_t o_req
);
  import smss_pkg::*;
  initial o_req = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk_sys);
    o_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk_sys);
    o_req.penable <= 1'b1;
    // no cycle limit here: a stalled slave is caught by the bench watchdog
    do begin
      @(posedge i_clk_sys);
    end while (i_rsp.pready !== 1'b1);
    q = i_rsp.prdata;
    e = i_rsp.pslverr;
    o_req <= '0;
  endtask
  // single device: it is both base and top
  task automatic start_up(input logic [5:0] adr, input int settle);
    logic [31:0] q;
    logic        e;
    repeat (settle) @(posedge i_clk_sys);
    xfer(1'b1, 12'h020, 32'h0, q, e);
    xfer(1'b1, 12'h010, 32'h1, q, e);
    xfer(1'b1, 12'h018, {26'h0, adr}, q, e);
    xfer(1'b1, 12'h01C, 32'h2, q, e);
    xfer(1'b0, 12'h020, 32'h0, q, e);
    xfer(1'b1, 12'h000, 32'h7F, q, e);
  endtask
endmodule
`default_nettype wire

// File: testbench/smss_top_tb.sv
// testbench of the supply monitor
`timescale 1ns/10ps
`default_nettype none
module smss_top_tb;
  import smss_pkg::*;
  localparam int unsigned BLANK = 8;
  logic          i_clk_sys = 1'b0;
  logic          i_rst = 1'b1;
  smss_cmp_t     cmp = '0;
  smss_apb_req_t req;
  smss_apb_rsp_t rsp;
  logic          dig_rst;
  logic          por;
  logic          bias_en;
  logic [31:0]   q;
  logic          e;
  int            i;
  int            err_total = 0;
  int            checks_done = 0;
  // flag table
  int unsigned   src [12] = '{14, 11, 10, 2, 7, 6, 4, 12, 5, 8, 1, 0};
  logic [11:0]   ofs [12] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
                              12'h004, 12'h008, 12'h008, 12'h008, 12'h008, 12'h00C};
  int unsigned   bitn [12] = '{0, 2, 3, 6, 4, 5, 0, 0, 1, 2, 3, 0};
  always #10 i_clk_sys = ~i_clk_sys;
  smss_top #(.BLANK_CYC(BLANK)) smss_top_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_cmp(cmp), .i_apb(req), .o_apb(rsp), .o_digital_reset(dig_rst),
    .o_power_on_reset(por), .o_bias_reference_enable(bias_en));
  smss_host_model smss_host_model_i (.i_clk_sys(i_clk_sys), .i_rsp(rsp), .o_req(req));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, s, x);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    smss_host_model_i.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    smss_host_model_i.xfer(1'b1, a, d, q, e);
  endtask
  task automatic pulse(input logic [14:0] m, input int n);
    @(posedge i_clk_sys);
    cmp <= m;
    repeat (n) @(posedge i_clk_sys);
    cmp <= '0;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (i = 0; i <= 9; i++) rc(12'(4 * i), 32'h0);
    wr(12'h018, 32'h7);
    rc(12'h018, 32'h0);
    smss_host_model_i.start_up(6'h05, 20);
    rc(12'h010, 32'h1);
    rc(12'h018, 32'h5);
    rc(12'h01C, 32'h2);
    wr(12'h014, 32'h1);
    @(negedge i_clk_sys);
    chk(32'(bias_en), 32'h1);
    repeat (BLANK + 4) @(posedge i_clk_sys);
    rc(12'h024, 32'h1);
    for (i = 0; i < 12; i++) begin
      pulse(15'(1 << src[i]), 1);
      rc(ofs[i], 32'h1 << bitn[i]);
      wr(ofs[i], 32'h1 << bitn[i]);
      rc(ofs[i], 32'h0);
    end
    smss_host_model_i.xfer(1'b1, 12'h040, 32'h1, q, e);
    chk(32'(e), 32'h1);
    smss_host_model_i.xfer(1'b0, 12'h030, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    // analog undervoltage: reset, bias dropped, cause kept afterwards
    pulse(15'h2000, 4);
    @(negedge i_clk_sys);
    chk(32'({dig_rst, por, bias_en}), 32'h4);
    repeat (3) @(posedge i_clk_sys);
    rc(12'h000, 32'h2);
    rc(12'h014, 32'h0);
    wr(12'h000, 32'h2);
    pulse(15'h0200, 4);
    @(negedge i_clk_sys);
    chk(32'({dig_rst, por}), 32'h2);
    repeat (3) @(posedge i_clk_sys);
    rc(12'h000, 32'h0);
    pulse(15'h2008, 4);
    @(negedge i_clk_sys);
    chk(32'({dig_rst, por}), 32'h1);
    repeat (3) @(posedge i_clk_sys);
    rc(12'h000, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
